// File: design/brd_decoder.sv
// Decoder end: remap address decode and configuration bank
`timescale 1ns/10ps
`include "brd_defines.svh"
module brd_decoder
    import brd_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Board reset held until load is done
    input wire logic boardLoadDone,
    output logic sysReset_n,
    // Link to the master end
    brd_link_if.device link,
    // Status for the user
    output logic [1:0] remapSel,
    output logic [1:0] csSel
);
    logic [31:0] miscCfg_r;
    logic sysRel_r;
    logic [31:0] rdData_r;
    logic slvErr_r;
    brd_target_t route_r;
    logic routeValid_r;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic inWin(input logic [39:0] a, input logic [39:0] b, input logic [39:0] s);
        inWin = (a >= b) && (a < b + s);
    endfunction

    // Both remap fields and the address in one path, one target out
    function automatic brd_target_t decode(input logic [39:0] a, input logic [1:0] rm, input logic [1:0] cs);
        decode = BRD_TGT_NONE;
        if (inWin(a, `BRD_LOW_BASE, `BRD_LOW_SIZE)) begin
            if (rm == `BRD_REMAP_AXI) begin
                decode = BRD_TGT_EXT_AXI;
            end else if (inWin(a, `BRD_NOR1_BASE, `BRD_NOR1_SIZE)) begin
                // Swap only in static mapping; fetches at zero follow it
                decode = (cs == `BRD_CS_SECONDARY) ? BRD_TGT_NOR_SECONDARY : BRD_TGT_NOR_PRIMARY;
            end else if (inWin(a, `BRD_NOR1_ALIAS, `BRD_NOR1_SIZE)) begin
                decode = BRD_TGT_NOR_PRIMARY;
            end else if (inWin(a, `BRD_NOR2_BASE, `BRD_NOR2_SIZE)) begin
                decode = BRD_TGT_NOR_SECONDARY;
            end else begin
                decode = BRD_TGT_STATIC_OTHER;
            end
        end else if (inWin(a, `BRD_CNTCTL_BASE, `BRD_CNTCTL_SIZE)) begin
            decode = BRD_TGT_CNT_CTRL;
        end else if (inWin(a, `BRD_CNTRD_BASE, `BRD_CNTRD_SIZE)) begin
            decode = BRD_TGT_CNT_READ;
        end else if (inWin(a, `BRD_BANK_BASE, `BRD_BANK_SIZE)) begin
            decode = BRD_TGT_CFG_BANK;
        end else if (inWin(a, `BRD_XAXI_BASE, `BRD_XAXI_SIZE)) begin
            // Static mode with external AXI switched off leaves it unrouted
            decode = (rm == `BRD_REMAP_STATIC_NOAXI) ? BRD_TGT_NONE : BRD_TGT_EXT_AXI;
        end
    endfunction

    assign remapSel = miscCfg_r[`BRD_REMAP_LSB +: 2];
    assign csSel = miscCfg_r[`BRD_CSSWAP_LSB +: 2];

    // ----------------------------------------------------------------
    // Reset release: system stays in reset until board load finishes
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sysRel_r <= 1'b0;
        end else if (clkEn && boardLoadDone) begin
            sysRel_r <= 1'b1;
        end
    end
    assign sysReset_n = sysRel_r;

    // ----------------------------------------------------------------
    // Configuration register: load port then APB
    // ----------------------------------------------------------------
    logic apbAccess;
    logic apbHitMisc;
    logic apbHitRo;
    logic [11:0] apbOff;
    assign apbAccess = link.psel && link.penable;
    assign apbOff = link.paddr[11:0];
    assign apbHitMisc = (apbOff == `BRD_OFF_MISC);
    assign apbHitRo = (apbOff == `BRD_OFF_TCID);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            miscCfg_r <= `BRD_MISC_RESET;
        end else if (clkEn) begin
            if (!sysRel_r && link.loadValid && link.loadOffset == `BRD_OFF_MISC) begin
                // Only this offset is loadable; others keep defaults
                miscCfg_r <= link.loadData;
            end else if (apbAccess && link.pwrite && apbHitMisc && link.pstrb == 4'hF) begin
                // Partial strobes are not supported and are dropped
                miscCfg_r <= link.pwdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one wait-free access phase
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_r <= 32'h0000_0000;
            slvErr_r <= 1'b0;
        end else if (clkEn && link.psel && !link.penable) begin
            rdData_r <= 32'h0000_0000;
            slvErr_r <= 1'b0;
            if (apbHitMisc) begin
                rdData_r <= miscCfg_r;
                slvErr_r <= link.pwrite && link.pstrb != 4'hF;
            end else if (apbHitRo) begin
                rdData_r <= link.pwrite ? 32'h0000_0000 : `BRD_TCID_VALUE;
            end else begin
                slvErr_r <= link.pwrite;
            end
        end
    end
    assign link.prdata = rdData_r;
    assign link.pslverr = slvErr_r && apbAccess;
    assign link.pready = 1'b1;

    // ----------------------------------------------------------------
    // Routing: target latched at acceptance, later writes do not alter it
    // ----------------------------------------------------------------
    assign link.reqReady = sysRel_r && clkEn;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            route_r <= BRD_TGT_NONE;
            routeValid_r <= 1'b0;
        end else if (clkEn) begin
            routeValid_r <= link.reqValid && sysRel_r;
            if (link.reqValid && sysRel_r) begin
                route_r <= decode(link.reqAddr, remapSel, csSel);
            end
        end
    end
    assign link.routeValid = routeValid_r;
    assign link.routeTarget = route_r;
endmodule // brd_decoder

// File: design/brd_defines.svh
// Constants for the boot remap decoder and its configuration bank
// ----------------------------------------------------------------
// How it works
// - remap bits pick static memory or AXI
// - one static encoding disables external AXI
// - select bits pick primary or secondary NOR
// - NOR swap only while static at zero
// - reset fetches follow current remap
// - no remap while running from region
// - board values loaded before reset release
// - dedicated load port from board controller
// - only some registers loaded, others default
// - registers reachable by config path and APB
// - APB bank decoded at fixed base
// - only full word writes supported
// - writes to read-only registers dropped
// - writes to unused words fail
// - reads return full 32 bits
// - unused word reads return zero
// - software uses read-modify-write
// - counter control window 20 bytes
// - counter read page 4KB
// - unspecified bits reset to zero; BRD_MISC_RESET (0x3D0) sets bit 4 and bits 6 to 9 to one
// ----------------------------------------------------------------
`ifndef BRD_DEFINES_SVH
`define BRD_DEFINES_SVH

`define BRD_ADDR_W 40
`define BRD_BANK_BASE 40'h00_7FFF_0000
`define BRD_BANK_SIZE 40'h00_0000_1000
`define BRD_OFF_MISC 12'h010
`define BRD_OFF_TCID 12'hFF8
`define BRD_MISC_RESET 32'h0000_03D0
`define BRD_TCID_VALUE 32'h0000_1234
`define BRD_REMAP_LSB 0
`define BRD_CSSWAP_LSB 4
`define BRD_LOW_BASE 40'h00_0000_0000
`define BRD_LOW_SIZE 40'h00_2000_0000
`define BRD_NOR1_BASE 40'h00_0000_0000
`define BRD_NOR1_SIZE 40'h00_0400_0000
`define BRD_NOR1_ALIAS 40'h00_0800_0000
`define BRD_NOR2_BASE 40'h00_0C00_0000
`define BRD_NOR2_SIZE 40'h00_0400_0000
`define BRD_XAXI_BASE 40'h00_4000_0000
`define BRD_XAXI_SIZE 40'h00_3FC0_0000
`define BRD_CNTCTL_BASE 40'h00_2A43_0000
`define BRD_CNTCTL_SIZE 40'h00_0000_0014
`define BRD_CNTRD_BASE 40'h00_2A80_0000
`define BRD_CNTRD_SIZE 40'h00_0000_1000
`define BRD_REMAP_AXI 2'h1
`define BRD_REMAP_STATIC_NOAXI 2'h2
`define BRD_CS_SECONDARY 2'h1

`endif

// File: design/brd_pkg.sv
// Types shared by both ends of the boot remap decoder
package brd_pkg;
    typedef enum logic [3:0] {
        BRD_TGT_NONE,
        BRD_TGT_NOR_PRIMARY,
        BRD_TGT_NOR_SECONDARY,
        BRD_TGT_STATIC_OTHER,
        BRD_TGT_EXT_AXI,
        BRD_TGT_CFG_BANK,
        BRD_TGT_CNT_CTRL,
        BRD_TGT_CNT_READ
    } brd_target_t;

    typedef enum logic [1:0] {
        BRD_APB_IDLE,
        BRD_APB_SETUP,
        BRD_APB_ACCESS
    } brd_apb_state_t;
endpackage

// File: design/brd_link_if.sv
// Interface joining the master end and the decoder end
`timescale 1ns/10ps
interface brd_link_if;
    // Transaction request and routed answer
    logic reqValid;
    logic reqReady;
    logic [39:0] reqAddr;
    logic routeValid;
    brd_pkg::brd_target_t routeTarget;
    // APB to the configuration bank
    logic psel;
    logic penable;
    logic pwrite;
    logic [39:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Board configuration load port
    logic loadValid;
    logic [11:0] loadOffset;
    logic [31:0] loadData;

    modport device (
        input reqValid, reqAddr, psel, penable, pwrite, paddr, pwdata, pstrb, loadValid, loadOffset, loadData,
        output reqReady, routeValid, routeTarget, prdata, pready, pslverr
    );
    modport master (
        output reqValid, reqAddr, psel, penable, pwrite, paddr, pwdata, pstrb, loadValid, loadOffset, loadData,
        input reqReady, routeValid, routeTarget, prdata, pready, pslverr
    );
endinterface

// File: design/brd_master.sv
// Master end: board loader, APB master and request issuer
`timescale 1ns/10ps
`include "brd_defines.svh"
module brd_master
    import brd_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Board load command
    input wire logic bootLoad,
    input wire logic [11:0] bootOffset,
    input wire logic [31:0] bootData,
    // Transaction request
    input wire logic txnValid,
    input wire logic [39:0] txnAddr,
    output logic txnReady,
    output logic [3:0] txnTarget,
    output logic txnDone,
    // Register command
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [11:0] cmdOffset,
    input wire logic [31:0] cmdData,
    output logic cmdBusy,
    output logic [31:0] cmdRdata,
    output logic cmdErr,
    output logic cmdDone,
    // Link
    brd_link_if.master link
);
    brd_apb_state_t st_r;
    logic [39:0] paddr_r;
    logic [31:0] pwdata_r;
    logic pwrite_r;
    logic [31:0] rd_r;
    logic err_r;
    logic done_r;

    // Board load passes straight through before reset release
    assign link.loadValid = bootLoad;
    assign link.loadOffset = bootOffset;
    assign link.loadData = bootData;

    // Requests go straight to the decoder
    assign link.reqValid = txnValid;
    assign link.reqAddr = txnAddr;
    assign txnReady = link.reqReady;
    assign txnDone = link.routeValid;
    assign txnTarget = link.routeTarget;

    // ----------------------------------------------------------------
    // APB master: always full-word strobes
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= BRD_APB_IDLE;
            paddr_r <= 40'h00_0000_0000;
            pwdata_r <= 32'h0000_0000;
            pwrite_r <= 1'b0;
        end else if (clkEn) begin
            case (st_r)
                BRD_APB_IDLE: begin
                    if (cmdValid) begin
                        st_r <= BRD_APB_SETUP;
                        paddr_r <= `BRD_BANK_BASE | {28'h000_0000, cmdOffset};
                        pwdata_r <= cmdData;
                        pwrite_r <= cmdWrite;
                    end
                end
                BRD_APB_SETUP: begin
                    st_r <= BRD_APB_ACCESS;
                end
                BRD_APB_ACCESS: begin
                    if (link.pready) begin
                        st_r <= BRD_APB_IDLE;
                    end
                end
                default: begin
                    st_r <= BRD_APB_IDLE;
                end
            endcase
        end
    end

    // Results captured at the end of the access
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_r <= 32'h0000_0000;
            err_r <= 1'b0;
            done_r <= 1'b0;
        end else if (clkEn) begin
            done_r <= (st_r == BRD_APB_ACCESS) && link.pready;
            if (st_r == BRD_APB_ACCESS && link.pready) begin
                rd_r <= link.prdata;
                err_r <= link.pslverr;
            end
        end
    end

    assign link.psel = (st_r != BRD_APB_IDLE);
    assign link.penable = (st_r == BRD_APB_ACCESS);
    assign link.paddr = paddr_r;
    assign link.pwdata = pwdata_r;
    assign link.pwrite = pwrite_r;
    assign link.pstrb = 4'hF;
    assign cmdBusy = (st_r != BRD_APB_IDLE);
    assign cmdRdata = rd_r;
    assign cmdErr = err_r;
    assign cmdDone = done_r;
endmodule // brd_master

// File: tb/brd_link_monitor.sv
// Checker for the configuration bank side of the link
`timescale 1ns/10ps
`include "brd_defines.svh"
module brd_link_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bank access signals
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [39:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // -----------------------------------------
    // Decode helpers and access phases
    // -----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    logic [11:0] regOff;
    logic known;
    // Only the misc word (stored) and the id word (constant) are decoded
    assign regOff = paddr[11:0];
    assign known = (regOff == `BRD_OFF_MISC) || (regOff == `BRD_OFF_TCID);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        psel && penable && pready;
    endsequence
    chk_setup_then_access:
        assert property (apb_setup |=> psel && penable && $stable(paddr) && $stable(pwrite))
        else $error("access phase did not follow setup");
    chk_access_one_cycle:
        assert property (psel && penable |-> pready) else $error("bank stalled an access");
    chk_access_ends:
        assert property (apb_access |=> !penable) else $error("access phase held too long");
    chk_full_word_write:
        assert property (psel && pwrite |-> pstrb == 4'hF) else $error("partial word write issued");
    chk_unused_write_fails:
        assert property (apb_access ##0 (pwrite && !known) |-> pslverr) else $error("unused write did not fail");
    chk_ro_write_quiet:
        assert property (apb_access ##0 (pwrite && regOff == `BRD_OFF_TCID) |-> !pslverr)
        else $error("read-only write flagged");
    chk_unused_read_zero:
        assert property (apb_access ##0 (!pwrite && !known) |-> prdata == 32'h0 && !pslverr)
        else $error("unused read not zero");
    chk_id_read_whole:
        assert property (apb_access ##0 (!pwrite && regOff == `BRD_OFF_TCID) |-> prdata == `BRD_TCID_VALUE)
        else $error("id word read wrong");
endmodule // brd_link_monitor

// File: tb/boot_remap_address_decoder_tb.sv
// Testbench joining the master end and the decoder end
`timescale 1ns/10ps
`include "brd_defines.svh"
module boot_remap_address_decoder_tb import brd_pkg::*; ;
    typedef struct {logic [31:0] misc; logic [39:0] addr; brd_target_t tgt;} brd_route_t;
    logic core_clk, reset_n, clkEn, boardLoadDone, sysReset_n, bootLoad, txnValid, txnReady, txnDone;
    logic cmdValid, cmdWrite, cmdBusy, cmdErr, cmdDone, e;
    logic [1:0] remapSel, csSel;
    logic [11:0] bootOffset, cmdOffset;
    logic [31:0] bootData, cmdData, cmdRdata, rd;
    logic [39:0] txnAddr;
    logic [3:0] txnTarget;
    int err_total, n_tests;
    // Misc value, address, expected target
    brd_route_t routes[14] = '{'{32'h10, 40'h0, BRD_TGT_NOR_SECONDARY}, '{32'h10, 40'h0C00_0000, BRD_TGT_NOR_SECONDARY},
        '{32'h10, 40'h0800_0000, BRD_TGT_NOR_PRIMARY}, '{32'h11, 40'h0, BRD_TGT_EXT_AXI},
        '{32'h11, 40'h0C00_0000, BRD_TGT_EXT_AXI}, '{32'h0, 40'h4000_0000, BRD_TGT_EXT_AXI},
        '{32'h2, 40'h4000_0000, BRD_TGT_NONE}, '{32'h12, 40'h0, BRD_TGT_NOR_SECONDARY},
        '{32'h0, 40'h2A43_0013, BRD_TGT_CNT_CTRL}, '{32'h0, 40'h2A43_0014, BRD_TGT_NONE},
        '{32'h0, 40'h2A80_0FFF, BRD_TGT_CNT_READ}, '{32'h0, 40'h2A80_1000, BRD_TGT_NONE},
        '{32'h0, 40'h7FFF_0000, BRD_TGT_CFG_BANK}, '{32'h0, 40'h0, BRD_TGT_NOR_PRIMARY}};
    brd_link_if link_if();
    brd_decoder brd_decoder_inst (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
        .boardLoadDone(boardLoadDone), .sysReset_n(sysReset_n), .link(link_if), .remapSel(remapSel), .csSel(csSel));
    brd_master brd_master_inst (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .bootLoad(bootLoad),
        .bootOffset(bootOffset), .bootData(bootData), .txnValid(txnValid), .txnAddr(txnAddr), .txnReady(txnReady),
        .txnTarget(txnTarget), .txnDone(txnDone), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdOffset(cmdOffset),
        .cmdData(cmdData), .cmdBusy(cmdBusy), .cmdRdata(cmdRdata), .cmdErr(cmdErr), .cmdDone(cmdDone), .link(link_if));
    brd_link_monitor brd_link_monitor_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(link_if.psel),
        .penable(link_if.penable), .pwrite(link_if.pwrite), .paddr(link_if.paddr), .pstrb(link_if.pstrb),
        .prdata(link_if.prdata), .pready(link_if.pready), .pslverr(link_if.pslverr));
    // ----------------------------------
    // Shared tasks
    // ----------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    // Whole-word command; waits for its done pulse under a bound
    task automatic reg_access(input logic w, input logic [11:0] off, input logic [31:0] d,
        output logic [31:0] r, output logic er);
        cmdValid = 1'b1;
        cmdWrite = w;
        cmdOffset = off;
        cmdData = d;
        @(negedge core_clk);
        cmdValid = 1'b0;
        check(cmdBusy, 1'b1);
        for (int i = 0; i < 8 && cmdDone !== 1'b1; i++) @(negedge core_clk);
        check(cmdDone, 1'b1);
        r = cmdRdata;
        er = cmdErr;
    endtask
    // Routing answer is due one cycle after the request is taken
    task automatic txn(input logic [39:0] a, input brd_target_t t);
        txnValid = 1'b1;
        txnAddr = a;
        @(negedge core_clk);
        txnValid = 1'b0;
        check(txnDone, 1'b1);
        check(txnTarget, t);
    endtask
    task automatic print_verdict;
        $display("Mismatches %0d of %0d comparisons", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Generous bound: the sequence needs about a hundred cycles
    initial begin
        #200000;
        err_total++;
        print_verdict;
    end
    // ----------------------------------
    // Main sequence
    // ----------------------------------
    initial begin
        {reset_n, boardLoadDone, bootLoad, txnValid, cmdValid, cmdWrite} = 6'h0;
        {bootOffset, cmdOffset, bootData, cmdData, txnAddr} = 128'h0;
        clkEn = 1'b1;
        err_total = 0;
        n_tests = 0;
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        check(sysReset_n, 1'b0);
        check(txnReady, 1'b0);
        check({remapSel, csSel}, 4'h1);
        reg_access(1'b0, `BRD_OFF_MISC, 32'h0, rd, e);
        check(rd, `BRD_MISC_RESET);
        // Board load lands before the system is let go
        bootLoad = 1'b1;
        bootOffset = `BRD_OFF_MISC;
        @(negedge core_clk);
        bootLoad = 1'b0;
        @(negedge core_clk);
        check(csSel, 2'h0);
        boardLoadDone = 1'b1;
        repeat (2) @(negedge core_clk);
        check(sysReset_n, 1'b1);
        txn(40'h0, BRD_TGT_NOR_PRIMARY);
        foreach (routes[i]) begin
            // Remap changes only between fetches, never during one
            reg_access(1'b1, `BRD_OFF_MISC, routes[i].misc, rd, e);
            check(remapSel, routes[i].misc[1:0]);
            txn(routes[i].addr, routes[i].tgt);
        end
        reg_access(1'b1, `BRD_OFF_TCID, 32'hFFFF_FFFF, rd, e);
        check(e, 1'b0);
        reg_access(1'b0, `BRD_OFF_TCID, 32'h0, rd, e);
        check(rd, `BRD_TCID_VALUE);
        reg_access(1'b1, 12'h020, 32'h5A5A_5A5A, rd, e);
        check(e, 1'b1);
        reg_access(1'b0, 12'h020, 32'h0, rd, e);
        check(rd, 32'h0000_0000);
        check(e, 1'b0);
        reg_access(1'b1, `BRD_OFF_MISC, 32'h0000_03D2, rd, e);
        reg_access(1'b0, `BRD_OFF_MISC, 32'h0, rd, e);
        check(rd, 32'h0000_03D2);
        // Read-modify-write: flip only the chip-select field
        reg_access(1'b1, `BRD_OFF_MISC, rd ^ 32'h0000_0030, rd, e);
        reg_access(1'b0, `BRD_OFF_MISC, 32'h0, rd, e);
        check(rd, 32'h0000_03E2);
        // Clock enable low freezes routing: no request taken
        clkEn = 1'b0;
        txnValid = 1'b1;
        txnAddr = 40'h0;
        @(negedge core_clk);
        check(txnReady, 1'b0);
        check(txnDone, 1'b0);
        txnValid = 1'b0;
        clkEn = 1'b1;
        @(negedge core_clk);
        print_verdict;
    end
endmodule // boot_remap_address_decoder_tb
